// ===== rtl/ext_mem_pkg.sv
// Purpose: Shared constants for the external data memory port
// Assumes: 25 MHz system clock
// Notes:   Widths and pin levels used by the port and its pin sampler
package ext_mem_pkg;
	localparam int          ADDR_W      = 14;
	localparam int          DATA_W      = 16;
	localparam logic [13:0] ADDR_RST    = 14'h0000;
	localparam logic [15:0] DATA_RST    = 16'h0000;
	localparam logic        PIN_ACTIVE  = 1'h0;
	localparam logic        PIN_IDLE    = 1'h1;
	localparam logic        SPACE_FIRST = 1'h0;
	localparam logic        SPACE_SECOND = 1'h1;

	// Port sequencer states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_READ  = 3'b001,
		ST_WRITE = 3'b010,
		ST_DONE  = 3'b011,
		ST_HELD  = 3'b100
	} port_state_t;
endpackage

// ===== rtl/pin_sync.sv
// Purpose: Three-stage sampler for a pin from outside the clock domain
// Assumes: One system clock
// Notes:   Output changes only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync
	import ext_mem_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic pin_in,
	output logic      level_out
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// Chain presets to the idle pin level; stage one feeds only stage two
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			s1_r      <= PIN_IDLE;
			s2_r      <= PIN_IDLE;
			s3_r      <= PIN_IDLE;
			level_out <= PIN_IDLE;
		end
		else
		begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				level_out <= s3_r;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/ext_mem_port.sv
// Purpose: Pin-level port to external data memory with bus hold handshake
// Assumes: Core issues one request at a time; wait and hold pins are asynchronous
// Notes:   Strobes last one cycle plus wait cycles on reads; grant waits for idle
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Bank select low first space, high second
// - Address holds last value between accesses
// - Address is zero from reset until first access
// - Sixteen-bit data bus, driven writes, sampled reads
// - Wait pin low stretches reads
// - Occupancy strobe low while using bus
// - Grant output low when hold allowed
// - Bus pins float while grant low
module ext_mem_port
	import ext_mem_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// Core side
	input  wire logic              req_valid,
	input  wire logic              req_write,
	input  wire logic              req_space,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	output logic                   req_ready,
	output logic                   rd_valid,
	output logic [DATA_W-1:0]      rd_data,
	// Memory pins
	output logic                   bank_sel,
	output logic                   bank_sel_oe,
	output logic [ADDR_W-1:0]      ext_addr_bus,
	output logic                   ext_addr_oe,
	input  wire logic [DATA_W-1:0] ext_data_in,
	output logic [DATA_W-1:0]      ext_data_out,
	output logic                   ext_data_oe,
	output logic                   mem_read_strobe,
	output logic                   mem_write_strobe,
	output logic                   strobe_oe,
	input  wire logic              wait_pin,
	input  wire logic              bus_hold_request,
	output logic                   bus_hold_grant,
	output logic                   bus_occupied_strobe
);
	port_state_t       state_r;
	port_state_t       state_nxt;
	logic              wait_lvl;
	logic              hold_lvl;
	logic              hold_req;
	logic              take_req;
	logic              read_end;
	logic              grant_nxt;

	// ----------------------------------------
	// Pin samplers
	// ----------------------------------------
	pin_sync u_wait_sync (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.pin_in    (wait_pin),
		.level_out (wait_lvl)
	);

	pin_sync u_hold_sync (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.pin_in    (bus_hold_request),
		.level_out (hold_lvl)
	);

	// ----------------------------------------
	// Sequencer decode
	// ----------------------------------------
	// Hold is only granted from idle, so a running access always completes
	assign hold_req  = (hold_lvl == PIN_ACTIVE);
	assign take_req  = (state_r == ST_IDLE) && !hold_req && req_valid;
	assign read_end  = (state_r == ST_READ) && (wait_lvl == PIN_IDLE);
	assign grant_nxt = (state_nxt == ST_HELD);

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
			begin
				if (hold_req)
					state_nxt = ST_HELD;
				else if (req_valid)
					state_nxt = req_write ? ST_WRITE : ST_READ;
			end
			ST_READ:  state_nxt = read_end ? ST_DONE : ST_READ;
			ST_WRITE: state_nxt = ST_DONE;
			ST_DONE:  state_nxt = ST_IDLE;
			ST_HELD:  state_nxt = hold_req ? ST_HELD : ST_IDLE;
			default:  state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// ----------------------------------------
	// Address, bank and data registers
	// ----------------------------------------
	// Address loads only on a new access, so it idles at its last value
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ext_addr_bus <= ADDR_RST;
			bank_sel     <= SPACE_FIRST;
			ext_data_out <= DATA_RST;
		end
		else if (take_req)
		begin
			ext_addr_bus <= req_addr;
			bank_sel     <= req_space;
			if (req_write)
				ext_data_out <= req_wdata;
		end
	end

	// Read data captured on the cycle the sampled wait level shows ready
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rd_valid <= 1'h0;
			rd_data  <= DATA_RST;
		end
		else
		begin
			rd_valid <= read_end;
			if (read_end)
				rd_data <= ext_data_in;
		end
	end

	// ----------------------------------------
	// Strobes, grant and enables
	// ----------------------------------------
	// All pin controls registered from next state so they change together
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			mem_read_strobe     <= PIN_IDLE;
			mem_write_strobe    <= PIN_IDLE;
			bus_occupied_strobe <= PIN_IDLE;
			bus_hold_grant      <= PIN_IDLE;
			strobe_oe           <= 1'h1;
			bank_sel_oe         <= 1'h1;
			ext_addr_oe         <= 1'h1;
			ext_data_oe         <= 1'h0;
			req_ready           <= 1'h0;
		end
		else
		begin
			mem_read_strobe     <= (state_nxt == ST_READ) ? PIN_ACTIVE : PIN_IDLE;
			mem_write_strobe    <= (state_nxt == ST_WRITE) ? PIN_ACTIVE : PIN_IDLE;
			bus_occupied_strobe <= (state_nxt == ST_READ || state_nxt == ST_WRITE)
				? PIN_ACTIVE : PIN_IDLE;
			bus_hold_grant      <= grant_nxt ? PIN_ACTIVE : PIN_IDLE;
			strobe_oe           <= !grant_nxt;
			bank_sel_oe         <= !grant_nxt;
			ext_addr_oe         <= !grant_nxt;
			ext_data_oe         <= (state_nxt == ST_WRITE);
			req_ready           <= take_req;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_read_start;
		take_req && !req_write;
	endsequence

	sequence s_read_strobe;
		mem_read_strobe == PIN_ACTIVE;
	endsequence

	chk_bank_follows_space: assert property (@(posedge sys_clk) disable iff (rst)
		take_req |=> bank_sel == $past(req_space))
		else $error("bank select does not match requested space");

	chk_addr_holds_idle: assert property (@(posedge sys_clk) disable iff (rst)
		!take_req |=> $stable(ext_addr_bus))
		else $error("address changed without an access");

	chk_addr_reset_zero: assert property (@(posedge sys_clk)
		rst |=> ext_addr_bus == ADDR_RST)
		else $error("address not zero after reset");

	chk_read_wait_stretch: assert property (@(posedge sys_clk) disable iff (rst)
		(state_r == ST_READ && wait_lvl == PIN_ACTIVE) |=> mem_read_strobe == PIN_ACTIVE)
		else $error("read strobe ended while wait active");

	chk_read_seq: assert property (@(posedge sys_clk) disable iff (rst)
		s_read_start |=> s_read_strobe ##0 mem_write_strobe == PIN_IDLE)
		else $error("read strobe missing after read request");

	chk_one_strobe: assert property (@(posedge sys_clk) disable iff (rst)
		!(mem_read_strobe == PIN_ACTIVE && mem_write_strobe == PIN_ACTIVE))
		else $error("both strobes active");

	chk_occupied_strobe: assert property (@(posedge sys_clk) disable iff (rst)
		(mem_read_strobe == PIN_ACTIVE || mem_write_strobe == PIN_ACTIVE)
			|-> bus_occupied_strobe == PIN_ACTIVE)
		else $error("bus strobe high during access");

	chk_grant_floats: assert property (@(posedge sys_clk) disable iff (rst)
		bus_hold_grant == PIN_ACTIVE |-> !(ext_addr_oe || ext_data_oe || strobe_oe || bank_sel_oe))
		else $error("pins driven while hold granted");

	chk_grant_no_access: assert property (@(posedge sys_clk) disable iff (rst)
		bus_hold_grant == PIN_ACTIVE |-> bus_occupied_strobe == PIN_IDLE ##1 !req_ready)
		else $error("access overlaps hold grant");

	chk_grant_follows_req: assert property (@(posedge sys_clk) disable iff (rst)
		(hold_req && state_r == ST_IDLE) |=> bus_hold_grant == PIN_ACTIVE)
		else $error("hold not granted from idle");
endmodule
`default_nettype wire

// ===== sim/ext_mem_model.sv
// Purpose: Far side: data memory plus outside bus master
// Assumes: Memory keeps 16 words per space
// Notes:   Undriven data shows the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model
	import ext_mem_pkg::*;
#(
	parameter int WAIT_N = 4
)
(
	input  wire logic              sys_clk,
	input  wire logic              bank_sel,
	input  wire logic [ADDR_W-1:0] ext_addr_bus,
	input  wire logic [DATA_W-1:0] ext_data_out,
	input  wire logic              mem_read_strobe,
	input  wire logic              mem_write_strobe,
	input  wire logic              slow,
	input  wire logic              want_bus,
	output logic [DATA_W-1:0]      ext_data_in,
	output logic                   wait_pin,
	output logic                   bus_hold_request
);
	logic [DATA_W-1:0] mem_r [32];
	logic [DATA_W-1:0] last_r = 16'h0000;
	int                rd_cnt = 0;
	// Store on write strobe; count read cycles to pace wait
	always @(posedge sys_clk)
	begin
		if (mem_write_strobe == PIN_ACTIVE)
			mem_r[{bank_sel, ext_addr_bus[3:0]}] <= ext_data_out;
		rd_cnt <= (mem_read_strobe == PIN_ACTIVE) ? rd_cnt + 1 : 0;
		if (mem_read_strobe == PIN_ACTIVE)
			last_r <= ext_data_in;
	end
	// Slow mode keeps wait low ahead of the strobe, as the sampler lags
	assign wait_pin = !slow || rd_cnt >= WAIT_N;
	assign ext_data_in = (mem_read_strobe == PIN_ACTIVE) ?
		mem_r[{bank_sel, ext_addr_bus[3:0]}] : ~last_r;
	assign bus_hold_request = !want_bus;
endmodule
`default_nettype wire

// ===== sim/tb_ext_data_memory_port_with_hold.sv
// Purpose: Self-checking bench for the data memory port
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Run ends only through test_done
`timescale 1ns/1ps
`default_nettype none
module tb_ext_data_memory_port_with_hold
	import ext_mem_pkg::*;
;
	localparam int WAIT_N = 4;
	logic              sys_clk = 0, rst = 1, slow = 0, want_bus = 0, seen_bank;
	logic              req_valid = 0, req_write = 0, req_space = 0, req_ready, rd_valid;
	logic [ADDR_W-1:0] req_addr = '0, ext_addr_bus;
	logic [DATA_W-1:0] req_wdata = '0, rd_data, ext_data_in, ext_data_out, seen_data;
	logic              bank_sel, bank_sel_oe, ext_addr_oe, ext_data_oe, strobe_oe;
	logic              mem_read_strobe, mem_write_strobe, wait_pin;
	logic              bus_hold_request, bus_hold_grant, bus_occupied_strobe;
	int                fail_count = 0, check_count = 0, cycles = 0, rd_low = 0;
	ext_mem_port i_ext_mem_port (.sys_clk, .rst, .req_valid, .req_write, .req_space,
		.req_addr, .req_wdata, .req_ready, .rd_valid, .rd_data, .bank_sel, .bank_sel_oe,
		.ext_addr_bus, .ext_addr_oe, .ext_data_in, .ext_data_out, .ext_data_oe,
		.mem_read_strobe, .mem_write_strobe, .strobe_oe, .wait_pin, .bus_hold_request,
		.bus_hold_grant, .bus_occupied_strobe);
	ext_mem_model #(.WAIT_N(WAIT_N)) i_ext_mem_model (.sys_clk, .bank_sel, .ext_addr_bus,
		.ext_data_out, .mem_read_strobe, .mem_write_strobe, .slow, .want_bus,
		.ext_data_in, .wait_pin, .bus_hold_request);
	always #20 sys_clk = ~sys_clk;
	// Strobe watch on the settled edge; hang cut far past the ~110 cycles used
	always @(negedge sys_clk)
	begin
		cycles++;
		if (mem_read_strobe === PIN_ACTIVE)
			rd_low++;
		if (!(mem_read_strobe & mem_write_strobe))
			chk_bit("one strobe", 1'b1, mem_read_strobe | mem_write_strobe);
		// Occupancy low exactly while a strobe is low, high otherwise
		chk_bit("occupied", mem_read_strobe & mem_write_strobe, bus_occupied_strobe);
		if (cycles == 3000)
		begin
			fail_count++;
			test_done();
		end
	end
	task automatic chk_bit(input string what, input logic exp, input logic got);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic wait_for(ref logic sig, input logic lvl, input string what);
		int n;
		n = 0;
		while (sig !== lvl && n < 40)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk_bit(what, lvl, sig);
	endtask
	// One core request, held until taken; snapshots the pins while strobed
	task automatic access(input logic w, s, input logic [13:0] a, input logic [15:0] d);
		req_valid = 1'b1;
		req_write = w;
		req_space = s;
		req_addr = a;
		req_wdata = d;
		wait_for(req_ready, 1'b1, "req_ready");
		seen_bank = bank_sel;
		seen_data = ext_data_out;
		chk_bit("data drive", w, ext_data_oe);
		// Request stays up through the edge that samples ready high
		@(posedge sys_clk);
		#1;
		req_valid = 1'b0;
		if (!w)
			wait_for(rd_valid, 1'b1, "rd_valid");
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	task automatic sc_banks();
		for (int i = 0; i < 4; i++)
		begin
			access(i < 2, i[0], 14'h0005, 16'hA5A5 ^ {16{i[0]}});
			chk_bit("bank", i[0], seen_bank);
			chk_word("data", 16'hA5A5 ^ {16{i[0]}}, (i < 2) ? seen_data : rd_data);
		end
	endtask
	task automatic sc_wait();
		access(1'b1, 1'b1, 14'h3FFF, 16'h1234);
		repeat (6) @(posedge sys_clk);
		#1;
		chk_word("held addr", 16'h3FFF, 16'(ext_addr_bus));
		rd_low = 0;
		access(1'b0, 1'b1, 14'h3FFF, 16'h0000);
		chk_word("fast read", 16'h0001, 16'(rd_low));
		slow = 1'b1;
		repeat (6) @(posedge sys_clk);
		#1;
		rd_low = 0;
		access(1'b0, 1'b1, 14'h3FFF, 16'h0000);
		chk_bit("stretched", 1'b1, rd_low > WAIT_N);
		chk_word("slow data", 16'h1234, rd_data);
		slow = 1'b0;
		repeat (6) @(posedge sys_clk);
		#1;
	endtask
	// Hold raised with a write: write ends first, then a read stalls until release
	task automatic sc_hold();
		want_bus = 1'b1;
		access(1'b1, 1'b0, 14'h0002, 16'hC3C3);
		wait_for(bus_hold_grant, PIN_ACTIVE, "grant");
		chk_bit("float", 1'b0, bank_sel_oe | ext_addr_oe | ext_data_oe | strobe_oe);
		req_valid = 1'b1;
		req_write = 1'b0;
		repeat (8) @(posedge sys_clk);
		#1;
		chk_bit("stalled", PIN_IDLE, bus_occupied_strobe);
		want_bus = 1'b0;
		access(1'b0, 1'b0, 14'h0002, 16'h0000);
		chk_word("after hold", 16'hC3C3, rd_data);
		chk_bit("grant back", PIN_IDLE, bus_hold_grant);
		chk_bit("drive back", 1'b1, bank_sel_oe & ext_addr_oe & strobe_oe);
	endtask
	// Mid-run reset: address drops to zero and stays there until an access
	task automatic sc_reset();
		rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		chk_word("reset addr", 16'h0000, 16'(ext_addr_bus));
		repeat (5) @(posedge sys_clk);
		#1;
		chk_word("idle addr", 16'h0000, 16'(ext_addr_bus));
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		chk_word("reset addr", 16'h0000, 16'(ext_addr_bus));
		sc_banks();
		sc_wait();
		sc_reset();
		sc_hold();
		test_done();
	end
endmodule
`default_nettype wire
